/* frps_defines.svh */
`ifndef FRPS_DEFINES_SVH
`define FRPS_DEFINES_SVH
// recovery times in microseconds (program and faster) and milliseconds (sector, block, chip, status)
`define FRPS_CLK_MHZ 100
`define FRPS_T_DECODE_US 40
`define FRPS_T_READ_US 35
`define FRPS_T_PROGRAM_US 310
`define FRPS_T_SECTOR_MS 12
`define FRPS_T_BLOCK_MS 25
`define FRPS_T_CHIP_MS 100
`define FRPS_T_STATUS_MS 40
`define FRPS_CYC_DECODE (`FRPS_T_DECODE_US * `FRPS_CLK_MHZ)
`define FRPS_CYC_READ (`FRPS_T_READ_US * `FRPS_CLK_MHZ)
`define FRPS_CYC_PROGRAM (`FRPS_T_PROGRAM_US * `FRPS_CLK_MHZ)
`define FRPS_CYC_SECTOR (`FRPS_T_SECTOR_MS * 1000 * `FRPS_CLK_MHZ)
`define FRPS_CYC_BLOCK (`FRPS_T_BLOCK_MS * 1000 * `FRPS_CLK_MHZ)
`define FRPS_CYC_CHIP (`FRPS_T_CHIP_MS * 1000 * `FRPS_CLK_MHZ)
`define FRPS_CYC_STATUS (`FRPS_T_STATUS_MS * 1000 * `FRPS_CLK_MHZ)
`define FRPS_CNT_W 24
`endif

/* frps_pkg.sv */
package frps_pkg;
  // operation class active when the hardware reset hits
  typedef enum logic [2:0]
  {
    FRPS_OP_IDLE = 3'h0,
    FRPS_OP_DECODE = 3'h1,
    FRPS_OP_READ = 3'h2,
    FRPS_OP_PROGRAM = 3'h3,
    FRPS_OP_SECTOR = 3'h4,
    FRPS_OP_BLOCK = 3'h5,
    FRPS_OP_CHIP = 3'h6,
    FRPS_OP_STATUS = 3'h7
  } frps_op_type;
  typedef enum logic [3:0]
  {
    FRPS_ST_OFF = 4'h1,
    FRPS_ST_RESET = 4'h2,
    FRPS_ST_RECOVER = 4'h4,
    FRPS_ST_STANDBY = 4'h8
  } frps_state_type;
endpackage : frps_pkg

/* frps_sequencer.sv */
`timescale 1ns/10ps
`include "frps_defines.svh"
module frps_sequencer #(
  parameter int unsigned CYC_DECODE = `FRPS_CYC_DECODE,
  parameter int unsigned CYC_READ = `FRPS_CYC_READ,
  parameter int unsigned CYC_PROGRAM = `FRPS_CYC_PROGRAM,
  parameter int unsigned CYC_SECTOR = `FRPS_CYC_SECTOR,
  parameter int unsigned CYC_BLOCK = `FRPS_CYC_BLOCK,
  parameter int unsigned CYC_CHIP = `FRPS_CYC_CHIP,
  parameter int unsigned CYC_STATUS = `FRPS_CYC_STATUS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic supply_ok,
  input wire logic hw_reset_n,
  input wire frps_pkg::frps_op_type op_class,
  input wire logic set_write_permit,
  input wire logic clr_write_permit,
  input wire logic op_start,
  input wire logic op_done,
  output logic cmd_enable,
  output logic standby,
  output logic write_permit_latch,
  output logic operation_in_progress_flag,
  output logic op_abort,
  output logic so_oe_block,
  output frps_pkg::frps_op_type last_class
);
  import frps_pkg::*;

  logic supply_s1_q;
  logic supply_s2_q;
  logic rst_s1_q;
  logic rst_s2_q;
  frps_state_type state_q;
  frps_state_type state_d;
  logic [`FRPS_CNT_W-1:0] cnt_q;
  logic [`FRPS_CNT_W-1:0] cnt_d;
  logic [`FRPS_CNT_W-1:0] rec_len;
  frps_op_type class_q;
  logic wpl_q;
  logic wip_q;
  logic cmd_en_q;
  logic stby_q;
  logic abort_q;
  logic sohz_q;

  // pins from outside the clock domain
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      supply_s1_q <= 1'b0;
      supply_s2_q <= 1'b0;
      rst_s1_q <= 1'b1;
      rst_s2_q <= 1'b1;
    end
    else
    begin
      supply_s1_q <= supply_ok;
      supply_s2_q <= supply_s1_q;
      rst_s1_q <= hw_reset_n;
      rst_s2_q <= rst_s1_q;
    end
  end

  wire power_fail = !supply_s2_q;
  wire hw_reset = !rst_s2_q;
  wire any_reset = power_fail || hw_reset;
  wire running = (state_q == FRPS_ST_STANDBY);
  wire cnt_done = (cnt_q == '0);

  // recovery length chosen by the class captured at reset entry
  always_comb
  begin
    case (class_q)
      FRPS_OP_DECODE: rec_len = CYC_DECODE[`FRPS_CNT_W-1:0];
      FRPS_OP_READ: rec_len = CYC_READ[`FRPS_CNT_W-1:0];
      FRPS_OP_PROGRAM: rec_len = CYC_PROGRAM[`FRPS_CNT_W-1:0];
      FRPS_OP_SECTOR: rec_len = CYC_SECTOR[`FRPS_CNT_W-1:0];
      FRPS_OP_BLOCK: rec_len = CYC_BLOCK[`FRPS_CNT_W-1:0];
      FRPS_OP_CHIP: rec_len = CYC_CHIP[`FRPS_CNT_W-1:0];
      FRPS_OP_STATUS: rec_len = CYC_STATUS[`FRPS_CNT_W-1:0];
      default: rec_len = `FRPS_CNT_W'h1;
    endcase
  end

  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      FRPS_ST_OFF:
      begin
        if (!power_fail)
        begin
          state_d = FRPS_ST_STANDBY;
        end
      end
      FRPS_ST_RESET:
      begin
        if (!hw_reset)
        begin
          state_d = FRPS_ST_RECOVER;
          cnt_d = rec_len;
        end
      end
      FRPS_ST_RECOVER:
      begin
        if (cnt_done)
        begin
          state_d = FRPS_ST_STANDBY;
        end
        else
        begin
          cnt_d = cnt_q - `FRPS_CNT_W'h1;
        end
      end
      FRPS_ST_STANDBY:
      begin
        if (hw_reset)
        begin
          state_d = FRPS_ST_RESET;
        end
      end
      default: state_d = FRPS_ST_OFF;
    endcase
    if (power_fail)
    begin
      state_d = FRPS_ST_OFF;
      cnt_d = '0;
    end
    else if (hw_reset && state_q != FRPS_ST_OFF)
    begin
      state_d = FRPS_ST_RESET;
    end
  end

  // class latched on reset entry, idle when nothing ran
  wire enter_reset = hw_reset && !power_fail && (state_q == FRPS_ST_STANDBY);
  wire [2:0] class_in = wip_q ? op_class : FRPS_OP_IDLE;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= FRPS_ST_OFF;
      cnt_q <= '0;
      class_q <= FRPS_OP_IDLE;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      if (enter_reset)
      begin
        class_q <= frps_op_type'(class_in);
      end
    end
  end

  // volatile bits; any reset restores power-on defaults
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wpl_q <= 1'b0;
      wip_q <= 1'b0;
      abort_q <= 1'b0;
    end
    else
    begin
      abort_q <= enter_reset && wip_q;
      if (any_reset || !running)
      begin
        wpl_q <= 1'b0;
        wip_q <= 1'b0;
      end
      else
      begin
        if (set_write_permit)
        begin
          wpl_q <= 1'b1;
        end
        else if (clr_write_permit || op_start)
        begin
          wpl_q <= 1'b0;
        end
        if (op_start)
        begin
          wip_q <= 1'b1;
        end
        else if (op_done)
        begin
          wip_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cmd_en_q <= 1'b0;
      stby_q <= 1'b0;
      sohz_q <= 1'b1;
    end
    else
    begin
      cmd_en_q <= (state_d == FRPS_ST_STANDBY);
      stby_q <= (state_d == FRPS_ST_STANDBY) && !wip_q;
      sohz_q <= any_reset || (state_d == FRPS_ST_RESET) || (state_d == FRPS_ST_OFF);
    end
  end

  assign cmd_enable = cmd_en_q;
  assign standby = stby_q;
  assign write_permit_latch = wpl_q;
  assign operation_in_progress_flag = wip_q;
  assign op_abort = abort_q;
  assign so_oe_block = sohz_q;
  assign last_class = class_q;

  AST_NO_CMD_IN_RESET: assert property (@(posedge clk) disable iff (!resetn)
    (power_fail || state_q == FRPS_ST_RESET) |=> !cmd_enable)
    else $error("commands enabled during reset");
  AST_WPL_CLEARED: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == FRPS_ST_OFF) |=> !write_permit_latch)
    else $error("write permit survived power-fail");
  AST_SO_HIZ: assert property (@(posedge clk) disable iff (!resetn)
    any_reset |=> so_oe_block)
    else $error("data output not blocked in reset");
  AST_RECOVER_BLOCK: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == FRPS_ST_RECOVER && !cnt_done) |=> !cmd_enable)
    else $error("command enabled before recovery end");
  AST_RECOVER_LEN: assert property (@(posedge clk) disable iff (!resetn)
    $rose(state_q == FRPS_ST_RECOVER) |-> cnt_q == rec_len)
    else $error("recovery count wrong");
  AST_POWERUP_STANDBY: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == FRPS_ST_OFF && !power_fail) |=> state_q == FRPS_ST_STANDBY ##1 cmd_enable)
    else $error("no standby after power-up");
  AST_WIP_CLEARED: assert property (@(posedge clk) disable iff (!resetn)
    (state_q == FRPS_ST_RESET) |=> !operation_in_progress_flag && !write_permit_latch)
    else $error("volatile bits kept through reset");
  AST_ABORT: assert property (@(posedge clk) disable iff (!resetn)
    (enter_reset && wip_q) |=> op_abort ##1 !op_abort)
    else $error("abort pulse missing");
endmodule : frps_sequencer

/* frps_host_model.sv */
`timescale 1ns/10ps
module frps_host_model #(
  parameter int LOW_CYC = 20
) (
  input wire logic clk,
  input wire logic pulse_req,
  output logic hw_reset_n
);
  int low_left = 0;
  // pin held low for a full pulse width
  always @(posedge clk)
  begin
    if (pulse_req && low_left == 0)
      low_left <= LOW_CYC;
    else if (low_left > 0)
      low_left <= low_left - 1;
  end
  always @(negedge clk)
    hw_reset_n <= (low_left == 0);
endmodule : frps_host_model

/* testbench.sv */
`timescale 1ns/10ps
module testbench;
  import frps_pkg::*;
  localparam int LOW_CYC = 20;
  localparam int REC [8] = '{1, 12, 10, 20, 25, 30, 40, 35};
  logic clk, resetn, supply_ok, pulse_req, hw_reset_n, set_wp, clr_wp, op_start, op_done;
  logic cmd_enable, standby, wpl, busy, op_abort, so_oe_block;
  int abort_cnt = 0;
  frps_op_type op_class, last_class;
  int fail_count, checks;
  frps_sequencer #(.CYC_DECODE(REC[1]), .CYC_READ(REC[2]), .CYC_PROGRAM(REC[3]), .CYC_SECTOR(REC[4]),
    .CYC_BLOCK(REC[5]), .CYC_CHIP(REC[6]), .CYC_STATUS(REC[7])) DUT (.clk(clk), .resetn(resetn),
    .supply_ok(supply_ok), .hw_reset_n(hw_reset_n), .op_class(op_class), .set_write_permit(set_wp),
    .clr_write_permit(clr_wp), .op_start(op_start), .op_done(op_done), .cmd_enable(cmd_enable),
    .standby(standby), .write_permit_latch(wpl), .operation_in_progress_flag(busy),
    .op_abort(op_abort), .so_oe_block(so_oe_block), .last_class(last_class));
  frps_host_model #(.LOW_CYC(LOW_CYC)) host (.clk(clk), .pulse_req(pulse_req), .hw_reset_n(hw_reset_n));
  always @(posedge clk)
    if (op_abort === 1'b1)
      abort_cnt <= abort_cnt + 1;
  task automatic check_bit(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s exp %0h got %0h", name, exp, got);
    end
  endtask : check_bit
  task automatic check_class(input string name, input frps_op_type exp, input frps_op_type got);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s exp %0h got %0h", name, exp, got);
    end
  endtask : check_class
  task automatic complete_run();
    if (fail_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse
  // bound lies above the longest recovery
  task automatic wait_cmd(output int n);
    n = 0;
    while (cmd_enable !== 1'b1)
    begin
      @(negedge clk);
      n++;
      if (n > 200)
      begin
        fail_count++;
        complete_run();
      end
    end
  endtask : wait_cmd
  task automatic power_up();
    int n;
    repeat (16) @(negedge clk);
    check_bit("so_oe_block", 1'b1, so_oe_block);
    resetn = 1'b1;
    wait_cmd(n);
    check_bit("standby", 1'b1, standby);
    check_bit("wpl", 1'b0, wpl);
  endtask : power_up
  task automatic normal_op();
    pulse(set_wp);
    pulse(clr_wp);
    check_bit("wpl", 1'b0, wpl);
    op_class = FRPS_OP_READ;
    pulse(op_start);
    check_bit("busy", 1'b1, busy);
    pulse(op_done);
    @(negedge clk);
    check_bit("standby", 1'b1, standby);
  endtask : normal_op
  task automatic reset_class(input frps_op_type c);
    int n;
    int a0;
    pulse(set_wp);
    check_bit("wpl", 1'b1, wpl);
    op_class = c;
    if (c != FRPS_OP_IDLE)
      pulse(op_start);
    a0 = abort_cnt;
    pulse(pulse_req);
    repeat (LOW_CYC / 2) @(negedge clk);
    check_bit("so_oe_block", 1'b1, so_oe_block);
    check_bit("cmd_enable", 1'b0, cmd_enable);
    repeat (LOW_CYC / 2 + 1) @(negedge clk);
    // refused while still in reset, before recovery starts
    pulse(set_wp);
    wait_cmd(n);
    check_bit("recovery", 1'b1, n >= REC[int'(c)] && n <= REC[int'(c)] + 8);
    check_bit("abort", c != FRPS_OP_IDLE, abort_cnt != a0);
    check_bit("abort_once", 1'b1, abort_cnt - a0 <= 1);
    check_class("last_class", c, last_class);
    check_bit("wpl", 1'b0, wpl);
    check_bit("busy", 1'b0, busy);
    check_bit("standby", 1'b1, standby);
  endtask : reset_class
  task automatic power_fail();
    int n;
    op_class = FRPS_OP_PROGRAM;
    pulse(op_start);
    supply_ok = 1'b0;
    repeat (5) @(negedge clk);
    check_bit("cmd_enable", 1'b0, cmd_enable);
    check_bit("busy", 1'b0, busy);
    pulse(set_wp);
    check_bit("wpl", 1'b0, wpl);
    supply_ok = 1'b1;
    wait_cmd(n);
    check_bit("standby", 1'b1, standby);
  endtask : power_fail
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    fail_count = 0;
    checks = 0;
    resetn = 1'b0;
    supply_ok = 1'b1;
    pulse_req = 1'b0;
    set_wp = 1'b0;
    clr_wp = 1'b0;
    op_start = 1'b0;
    op_done = 1'b0;
    op_class = FRPS_OP_IDLE;
    power_up();
    normal_op();
    reset_class(FRPS_OP_IDLE);
    reset_class(FRPS_OP_DECODE);
    reset_class(FRPS_OP_READ);
    reset_class(FRPS_OP_PROGRAM);
    reset_class(FRPS_OP_SECTOR);
    reset_class(FRPS_OP_BLOCK);
    reset_class(FRPS_OP_CHIP);
    reset_class(FRPS_OP_STATUS);
    power_fail();
    complete_run();
  end
endmodule : testbench
